/* File: ssp_pkg.sv */
package ssp_pkg;

  // byte width on the wire
  localparam int unsigned BYTE_W = 8;

  // mode field values of the control word
  localparam logic [3:0] MODE_SLV7      = 4'h6;  // slave, 7-bit address
  localparam logic [3:0] MODE_SLV10     = 4'h7;  // slave, 10-bit address
  localparam logic [3:0] MODE_FW_MASTER = 4'hb;  // firmware master, slave idle
  localparam logic [3:0] MODE_SLV7_SP   = 4'he;  // 7-bit with start/stop irq
  localparam logic [3:0] MODE_SLV10_SP  = 4'hf;  // 10-bit with start/stop irq

  // field positions of the control word
  localparam int unsigned CTRL_OVF_BIT = 6;
  localparam int unsigned CTRL_EN_BIT  = 5;
  localparam int unsigned CTRL_MODE_HI = 3;
  localparam int unsigned CTRL_MODE_LO = 0;

  // port direction bits of the two pins (1 = input)
  localparam int unsigned DIR_SDA_BIT = 4;
  localparam int unsigned DIR_SCL_BIT = 3;

  // high address byte prefix for 10-bit addressing
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;

  // general call address, never answered
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;

  // bit count that closes a byte
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // reset values
  localparam logic [7:0] BUF_RESET  = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // status word carried to software
  typedef struct packed {
    logic start_seen;     // start seen last
    logic stop_seen;      // stop seen last
    logic data_not_addr;  // last byte was data
    logic update_addr;    // next address byte must be reloaded
    logic read_not_write; // master reads from us
    logic buf_full;       // buffer holds an unread byte
  } ssp_status_t;

  // synchronised view of the bus pins
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } ssp_bus_t;

  // engine states, gray along idle-shift-ack-tx-txack
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SHIFT  = 3'b001,
    ST_ACK    = 3'b011,
    ST_TX     = 3'b010,
    ST_TX_ACK = 3'b110
  } ssp_state_t;

endpackage

/* File: ssp_pin_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser and edge finder for the bus pins
module ssp_pin_sync (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output ssp_pkg::ssp_bus_t     bus
);

  logic [1:0] meta_q;   // first stage, read only by second stage
  logic [1:0] meta_d;
  logic [1:0] sync_q;   // second stage, safe to use
  logic [1:0] sync_d;
  logic [1:0] last_q;   // previous synced level for edges
  logic [1:0] last_d;

  // next values: pure shift chain
  always_comb begin
    meta_d = {scl_in, sda_in};
    sync_d = meta_q;
    last_d = sync_q;
  end

  // registers, idle bus is high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
      last_q <= 2'h3;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  // decode edges and start/stop from synced levels only
  always_comb begin
    bus.scl      = sync_q[1];
    bus.sda      = sync_q[0];
    bus.scl_rise = sync_q[1] & ~last_q[1];
    bus.scl_fall = ~sync_q[1] & last_q[1];
    bus.start    = sync_q[1] & last_q[1] & ~sync_q[0] & last_q[0];
    bus.stop     = sync_q[1] & last_q[1] & sync_q[0] & ~last_q[0];
  end

endmodule

/* File: ssp_i2c_slave.sv */
`timescale 1ns/1ps
// What this block does
// [R1] full slave, general call never acknowledged
// [R2] start/stop raise irq flag when enabled
// [R3] standard timing, 7-bit and 10-bit addresses
// [R4] software sets both pin directions to input
// [R5] port works only while enable set
// [R6] four-bit mode selects five modes
// [R7] firmware master mode keeps slave idle
// [R8] pins open drain when enabled and inputs
// [R9] status shows start, stop, da, ua, rw
// [R10] status is read only to software
// [R11] software exchanges data through buffer register
// [R12] hidden shift register moves sda bits
// [R13] receive double buffered, shift continues
// [R14] full byte goes to buffer, sets flag
// [R15] unread buffer: set overflow, drop byte
// [R16] address bytes compared with address register
// [R17] 10-bit: load high byte 11110 a9 a8 0
// [R18] after high match reload low eight bits
// [R19] acknowledge holds sda low ninth clock
module ssp_i2c_slave #(
  parameter int unsigned DATA_W = ssp_pkg::BYTE_W
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                scl_in,             // clock pin level
  input  wire logic                sda_in,             // data pin level
  input  wire logic [7:0]          serial_port_control, // control word
  input  wire logic [7:0]          port_c_direction,   // pin directions
  input  wire logic [DATA_W-1:0]   slave_address_register,
  input  wire logic [DATA_W-1:0]   tx_data,            // buffer write data
  input  wire logic                tx_write,           // buffer write strobe
  input  wire logic                buf_read,           // buffer read strobe
  input  wire logic                irq_clear,          // clears irq flag
  input  wire logic                ovf_clear,          // clears overflow
  output logic                     scl_out,
  output logic                     scl_oe_n,
  output logic                     sda_out,
  output logic                     sda_oe_n,
  output logic [DATA_W-1:0]        serial_rx_tx_buffer,
  output logic                     serial_port_irq_flag,
  output logic                     receive_overflow_flag,
  output ssp_pkg::ssp_status_t     serial_port_status
);

  if (DATA_W != ssp_pkg::BYTE_W) begin : g_chk
    $error("ssp_i2c_slave serves only 8-bit bytes");
  end

  ssp_pkg::ssp_bus_t bus;  // synchronised pins and events

  ssp_pin_sync u_sync (
    .clk    (clk),
    .rst    (rst),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .bus    (bus)
  );

  // control decode
  logic [3:0] mode;       // selected mode
  logic       enabled;    // port enable
  logic       pins_in;    // both pins set as inputs
  logic       slave_mode; // one of the four slave modes
  logic       ten_bit;    // 10-bit address mode
  logic       sp_irq;     // start/stop interrupts on
  logic       active;     // slave engine may run

  always_comb begin
    mode       = serial_port_control[ssp_pkg::CTRL_MODE_HI:ssp_pkg::CTRL_MODE_LO];
    enabled    = serial_port_control[ssp_pkg::CTRL_EN_BIT];  // see [R5]
    pins_in    = port_c_direction[ssp_pkg::DIR_SDA_BIT] & port_c_direction[ssp_pkg::DIR_SCL_BIT];  // see [R4]
    slave_mode = (mode == ssp_pkg::MODE_SLV7) | (mode == ssp_pkg::MODE_SLV10) |
                 (mode == ssp_pkg::MODE_SLV7_SP) | (mode == ssp_pkg::MODE_SLV10_SP);  // see [R6] [R7]
    ten_bit    = (mode == ssp_pkg::MODE_SLV10) | (mode == ssp_pkg::MODE_SLV10_SP);  // see [R3]
    sp_irq     = (mode == ssp_pkg::MODE_SLV7_SP) | (mode == ssp_pkg::MODE_SLV10_SP);
    active     = enabled & pins_in & slave_mode;  // see [R8]
  end

  // engine state
  ssp_pkg::ssp_state_t   state_q, state_d;
  logic [DATA_W-1:0]     shift_q, shift_d;  // hidden shift register
  logic [3:0]            cnt_q, cnt_d;      // bits of current byte
  logic                  ack_q, ack_d;      // drive ack in ack slot
  logic                  tx_next_q, tx_next_d;  // after ack go transmit
  logic [1:0]            aph_q, aph_d;      // 0 first addr, 1 low addr, 2 data
  logic                  hit10_q, hit10_d;  // full 10-bit match done
  logic [DATA_W-1:0]     buf_q, buf_d;
  logic                  irq_q, irq_d;
  logic                  ovf_q, ovf_d;
  logic                  sda_drv_q, sda_drv_d;  // pull sda low
  ssp_pkg::ssp_status_t  st_q, st_d;

  // byte decode helpers
  logic byte_done;   // eighth bit has passed its falling edge
  logic hi_match;    // first address byte matches
  logic lo_match;    // low 10-bit address byte matches
  logic rx_accept;   // buffer free for a new byte
  logic rx_set;      // a byte lands in the buffer this cycle

  always_comb begin
    byte_done = bus.scl_fall & (cnt_q == ssp_pkg::BITS_PER_BYTE);
    hi_match  = (shift_q[7:1] == slave_address_register[7:1]) &
                (shift_q[7:1] != ssp_pkg::GEN_CALL_ADDR);  // see [R16] [R1]
    if (ten_bit) begin
      hi_match = hi_match & (shift_q[7:3] == ssp_pkg::TEN_BIT_PREFIX);  // see [R17]
    end
    lo_match  = (shift_q == slave_address_register);  // see [R18]
    rx_accept = ~st_q.buf_full;  // see [R13]
  end

  // next state of the engine and its registers
  always_comb begin
    state_d   = state_q;
    shift_d   = shift_q;
    cnt_d     = cnt_q;
    ack_d     = ack_q;
    tx_next_d = tx_next_q;
    aph_d     = aph_q;
    hit10_d   = hit10_q;
    buf_d     = buf_q;
    st_d      = st_q;
    rx_set    = 1'b0;
    // software side of the buffer
    if (tx_write) begin
      buf_d = tx_data;  // see [R11]
    end
    if (buf_read) begin
      st_d.buf_full = 1'b0;
    end
    if (!active) begin
      // disabled or firmware master: engine idle, pins released
      state_d = ssp_pkg::ST_IDLE;  // see [R7]
      hit10_d = 1'b0;
    end else if (bus.start) begin
      // start or repeated start: expect an address byte
      state_d         = ssp_pkg::ST_SHIFT;
      cnt_d           = 4'h0;
      aph_d           = 2'h0;
      st_d.start_seen = 1'b1;  // see [R9]
      st_d.stop_seen  = 1'b0;
    end else if (bus.stop) begin
      state_d         = ssp_pkg::ST_IDLE;
      hit10_d         = 1'b0;
      st_d.stop_seen  = 1'b1;
      st_d.start_seen = 1'b0;
    end else begin
      unique case (state_q)
        ssp_pkg::ST_IDLE: begin
          // wait for a start
        end
        ssp_pkg::ST_SHIFT: begin
          if (bus.scl_rise && cnt_q != ssp_pkg::BITS_PER_BYTE) begin
            shift_d = {shift_q[6:0], bus.sda};  // see [R12]
            cnt_d   = cnt_q + 4'h1;
          end else if (byte_done) begin
            state_d   = ssp_pkg::ST_ACK;
            ack_d     = 1'b0;
            tx_next_d = 1'b0;
            if (aph_q == 2'h0) begin
              if (hi_match && (!ten_bit || !shift_q[0] || hit10_q)) begin
                st_d.data_not_addr  = 1'b0;
                st_d.read_not_write = shift_q[0];
                st_d.update_addr    = ten_bit & ~shift_q[0];
                tx_next_d           = shift_q[0];
                aph_d               = (ten_bit && !shift_q[0]) ? 2'h1 : 2'h2;
                ack_d               = rx_accept;
                rx_set              = rx_accept;
              end else begin
                state_d = ssp_pkg::ST_IDLE;  // not ours
              end
            end else if (aph_q == 2'h1) begin
              if (lo_match) begin
                hit10_d            = 1'b1;
                st_d.update_addr   = 1'b1;
                st_d.data_not_addr = 1'b0;
                aph_d              = 2'h2;
                ack_d              = rx_accept;
                rx_set             = rx_accept;
              end else begin
                state_d = ssp_pkg::ST_IDLE;
              end
            end else begin
              st_d.data_not_addr = 1'b1;
              st_d.update_addr   = 1'b0;
              ack_d              = rx_accept;  // see [R15]
              rx_set             = rx_accept;
            end
          end
        end
        ssp_pkg::ST_ACK: begin
          // ack slot ends at the ninth falling edge
          if (bus.scl_fall) begin
            cnt_d = 4'h0;
            if (!ack_q) begin
              state_d = ssp_pkg::ST_IDLE;
            end else if (tx_next_q) begin
              state_d = ssp_pkg::ST_TX;
              shift_d = buf_q;  // see [R11]
            end else begin
              state_d = ssp_pkg::ST_SHIFT;
            end
          end
        end
        ssp_pkg::ST_TX: begin
          // shift out on each falling edge after the bit was held
          if (bus.scl_fall) begin
            shift_d = {shift_q[6:0], 1'b0};
            cnt_d   = cnt_q + 4'h1;
            if (cnt_q == ssp_pkg::BITS_PER_BYTE - 4'h1) begin
              state_d = ssp_pkg::ST_TX_ACK;
            end
          end
        end
        ssp_pkg::ST_TX_ACK: begin
          // master acks low to ask for more
          if (bus.scl_rise) begin
            ack_d = ~bus.sda;
          end else if (bus.scl_fall) begin
            cnt_d   = 4'h0;
            state_d = ack_q ? ssp_pkg::ST_TX : ssp_pkg::ST_IDLE;
            shift_d = buf_q;
          end
        end
      endcase
    end
    if (rx_set) begin
      buf_d         = shift_q;  // see [R14]
      st_d.buf_full = 1'b1;
    end
  end

  // flags: hardware set wins over software clear
  logic ovf_set;  // byte dropped into a full buffer
  logic irq_set;  // byte event or start/stop event

  always_comb begin
    ovf_set = active & (state_q == ssp_pkg::ST_SHIFT) & byte_done & ~rx_accept &
              ((aph_q == 2'h2) | hi_match & (aph_q == 2'h0) | lo_match & (aph_q == 2'h1));  // see [R15]
    irq_set = rx_set |  // see [R14]
              (active & (state_q == ssp_pkg::ST_TX_ACK) & bus.scl_fall & ack_q) |
              (active & sp_irq & (bus.start | bus.stop));  // see [R2]
    irq_d   = irq_set | (irq_q & ~irq_clear);
    ovf_d   = ovf_set | (ovf_q & ~ovf_clear);
    // open drain: pull low only for ack or a zero data bit
    sda_drv_d = 1'b0;
    if (active && !bus.start && !bus.stop) begin
      if (state_d == ssp_pkg::ST_ACK) begin
        sda_drv_d = ack_d;  // see [R19]
      end else if (state_d == ssp_pkg::ST_TX) begin
        sda_drv_d = ~shift_d[7];
      end
    end
  end

  // registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q   <= ssp_pkg::ST_IDLE;
      shift_q   <= ssp_pkg::BUF_RESET;
      cnt_q     <= 4'h0;
      ack_q     <= 1'b0;
      tx_next_q <= 1'b0;
      aph_q     <= 2'h0;
      hit10_q   <= 1'b0;
      buf_q     <= ssp_pkg::BUF_RESET;
      st_q      <= '0;
      irq_q     <= 1'b0;
      ovf_q     <= 1'b0;
      sda_drv_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      shift_q   <= shift_d;
      cnt_q     <= cnt_d;
      ack_q     <= ack_d;
      tx_next_q <= tx_next_d;
      aph_q     <= aph_d;
      hit10_q   <= hit10_d;
      buf_q     <= buf_d;
      st_q      <= st_d;
      irq_q     <= irq_d;
      ovf_q     <= ovf_d;
      sda_drv_q <= sda_drv_d;
    end
  end

  // outputs straight from flops or tied constants; status has no software write path
  always_comb begin
    scl_out               = 1'b0;  // never stretches the clock
    scl_oe_n              = 1'b1;
    sda_out               = 1'b0;  // see [R8]
    sda_oe_n              = ~sda_drv_q;
    serial_rx_tx_buffer   = buf_q;
    serial_port_irq_flag  = irq_q;
    receive_overflow_flag = ovf_q;
    serial_port_status    = st_q;  // see [R10] [R9]
  end

endmodule

/* File: ssp_i2c_checker.sv */
`timescale 1ns/1ps
// concurrent checks on the slave's pins, flags and status
module ssp_i2c_checker #(
  parameter int unsigned DATA_W = 8
) (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 scl_in,
  input wire logic                 sda_in,
  input wire logic [7:0]           serial_port_control,
  input wire logic [7:0]           port_c_direction,
  input wire logic [DATA_W-1:0]    slave_address_register,
  input wire logic [DATA_W-1:0]    tx_data,
  input wire logic                 tx_write,
  input wire logic                 buf_read,
  input wire logic                 irq_clear,
  input wire logic                 ovf_clear,
  input wire logic                 scl_out,
  input wire logic                 scl_oe_n,
  input wire logic                 sda_out,
  input wire logic                 sda_oe_n,
  input wire logic [DATA_W-1:0]    serial_rx_tx_buffer,
  input wire logic                 serial_port_irq_flag,
  input wire logic                 receive_overflow_flag,
  input wire ssp_pkg::ssp_status_t serial_port_status
);
  // one domain: clock and reset given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // port switched off for two cycles
  sequence s_off;
    (!serial_port_control[ssp_pkg::CTRL_EN_BIT]) [*2];
  endsequence
  // firmware master mode held for two cycles
  sequence s_fwm;
    (serial_port_control[3:0] == ssp_pkg::MODE_FW_MASTER) [*2];
  endsequence
  // a pin left as output for two cycles
  sequence s_nodir;
    (port_c_direction[4:3] != 2'h3) [*2];
  endsequence

  AST_SCL_FREE: assert property (scl_oe_n && !scl_out)
    else $error("clock pin driven");
  AST_SDA_LOW: assert property (!sda_oe_n |-> !sda_out)
    else $error("data pin driven high");
  AST_OFF: assert property (s_off |-> sda_oe_n)
    else $error("data pin driven while disabled");
  AST_FWM: assert property (s_fwm |-> sda_oe_n)
    else $error("slave answers in master mode");
  AST_DIR: assert property (s_nodir |-> sda_oe_n)
    else $error("data pin driven with pins as outputs");
  AST_FULL_IRQ: assert property ($rose(serial_port_status.buf_full) |-> serial_port_irq_flag)
    else $error("byte stored without flag");
  AST_OVF_KEEP: assert property (receive_overflow_flag && !ovf_clear |=> receive_overflow_flag)
    else $error("overflow lost");
  AST_DROP: assert property (serial_port_status.buf_full && !tx_write && !buf_read
    |=> $stable(serial_rx_tx_buffer))
    else $error("full buffer overwritten");
  AST_ACK_HOLD: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
    else $error("data low too short");
  AST_SDA_CHG: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data changed while clock high");
  AST_EXCL: assert property (!(serial_port_status.start_seen && serial_port_status.stop_seen))
    else $error("start and stop both shown");
endmodule

bind ssp_i2c_slave ssp_i2c_checker #(.DATA_W(DATA_W)) chk (
  .clk, .rst, .scl_in, .sda_in, .serial_port_control, .port_c_direction,
  .slave_address_register, .tx_data, .tx_write, .buf_read, .irq_clear,
  .ovf_clear, .scl_out, .scl_oe_n, .sda_out, .sda_oe_n, .serial_rx_tx_buffer,
  .serial_port_irq_flag, .receive_overflow_flag, .serial_port_status
);

/* File: ssp_mst.sv */
`timescale 1ns/1ps
// behavioural bus master, 160 ns bit, 1 = line released
module ssp_mst (
  input  wire logic clk,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  localparam int Q = 40;  // quarter bit

  // bus idles released, pull-ups give high
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // one clock pulse, data sampled mid high phase
  task automatic pulse(output logic s);
    #Q scl_o = 1'b1;
    #Q s = sda_i;
    #Q scl_o = 1'b0;
    #Q;
  endtask
  // start or repeated start
  task automatic start();
    @(negedge clk);
    sda_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b0;
    #Q;
  endtask
  // stop, bus left released
  task automatic stop();
    sda_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b1;
    #Q;
  endtask
  // eight bits msb first, then the answer bit
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_o = b[i];
      pulse(s);
    end
    sda_o = 1'b1;
    pulse(s);
    ack = ~s;
  endtask
  // eight bits read, then our own answer bit
  task automatic rbyte(input logic mack, output logic [7:0] b);
    logic s;
    sda_o = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      pulse(s);
      b[i] = s;
    end
    sda_o = ~mack;
    pulse(s);
    sda_o = 1'b1;
  endtask
endmodule

/* File: i2c_slave_serial_port_tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("BAD %s exp %h got %h", n, e, g); \
  end \
end
module i2c_slave_serial_port_tb_top;
  logic                 clk, rst, txw, brd, iclr, oclr;
  logic                 m_scl, m_sda, scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic                 irq, ovf, ak;
  logic [7:0]           ctrl, dir, sadr, txd, rbuf, rb;
  ssp_pkg::ssp_status_t st;
  int                   fail_count, checks;
  wire                  scl = m_scl & (scl_oe_n | scl_out);  // open drain wire
  wire                  sda = m_sda & (sda_oe_n | sda_out);

  ssp_mst mst (.clk(clk), .sda_i(sda), .scl_o(m_scl), .sda_o(m_sda));
  ssp_i2c_slave dut (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .serial_port_control(ctrl), .port_c_direction(dir),
    .slave_address_register(sadr), .tx_data(txd), .tx_write(txw),
    .buf_read(brd), .irq_clear(iclr), .ovf_clear(oclr),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .serial_rx_tx_buffer(rbuf), .serial_port_irq_flag(irq),
    .receive_overflow_flag(ovf), .serial_port_status(st)
  );

  // software strobes {write, read, irq clear, ovf clear}
  task automatic sw(input logic [3:0] m);
    @(negedge clk);
    {txw, brd, iclr, oclr} = m;
    @(negedge clk);
    {txw, brd, iclr, oclr} = 4'h0;
  endtask
  // idle values after reset
  task automatic t_reset();
    `CHK("rst buf", ssp_pkg::BUF_RESET, rbuf)
    `CHK("rst st", 6'h00, st)
    `CHK("rst oe", 2'h3, {scl_oe_n, sda_oe_n})
  endtask
  // 7-bit write, then a byte into a full buffer
  task automatic t_write();
    mst.start();
    mst.wbyte(8'ha4, ak);
    `CHK("adr ack", 1'b1, ak)
    `CHK("adr irq", 1'b1, irq)
    sw(4'h6);
    mst.wbyte(8'h3c, ak);
    `CHK("d ack", 1'b1, ak)
    `CHK("d buf", 8'h3c, rbuf)
    `CHK("da", 1'b1, st.data_not_addr)
    mst.wbyte(8'hc3, ak);
    `CHK("ov nack", 1'b0, ak)
    `CHK("ovf", 1'b1, ovf)
    `CHK("ov buf", 8'h3c, rbuf)
    mst.stop();
    `CHK("stop", 1'b1, st.stop_seen)
    sw(4'h7);
  endtask
  // cases that must stay silent: {ctrl, dir, own address, sent address}
  task automatic t_refuse();
    logic [31:0] v [5] = '{32'h2618a4a6, 32'h26180000, 32'h0618a4a4, 32'h2b18a4a4, 32'h2610a4a4};
    foreach (v[i]) begin
      @(negedge clk);
      {ctrl, dir, sadr} = v[i][31:8];
      mst.start();
      mst.wbyte(v[i][7:0], ak);
      `CHK("nack", 1'b0, ak)
      `CHK("no irq", 1'b0, irq)
      mst.stop();
    end
    {ctrl, dir, sadr} = 24'h2618a4;
  endtask
  // read: buffer written during the address answer, master acks once
  task automatic t_read();
    mst.start();
    fork
      mst.wbyte(8'ha5, ak);
      begin
        @(posedge irq);
        sw(4'h8);
      end
    join
    `CHK("rd adr ack", 1'b1, ak)
    `CHK("rw", 1'b1, st.read_not_write)
    sw(4'h2);
    mst.rbyte(1'b1, rb);
    `CHK("rd", 8'h5a, rb)
    `CHK("rd irq", 1'b1, irq)
    mst.rbyte(1'b0, rb);
    `CHK("rd2", 8'h5a, rb)
    mst.stop();
    sw(4'h7);
  endtask
  // 10-bit: high byte, reload, low byte, data
  task automatic t_ten();
    @(negedge clk);
    ctrl = 8'h27;
    sadr = 8'hf4;
    mst.start();
    mst.wbyte(8'hf4, ak);
    `CHK("hi ack", 1'b1, ak)
    `CHK("ua", 1'b1, st.update_addr)
    sadr = 8'hb5;
    sw(4'h6);
    mst.wbyte(8'hb5, ak);
    `CHK("lo ack", 1'b1, ak)
    sw(4'h6);
    mst.wbyte(8'h11, ak);
    `CHK("10b dat", 8'h11, rbuf)
    mst.stop();
    sw(4'h7);
  endtask
  // start flag per slave mode, irq only with start/stop enabled
  task automatic t_modes();
    logic [3:0] m [4] = '{ssp_pkg::MODE_SLV7, ssp_pkg::MODE_SLV10,
                          ssp_pkg::MODE_SLV7_SP, ssp_pkg::MODE_SLV10_SP};
    foreach (m[i]) begin
      @(negedge clk);
      ctrl = {4'h2, m[i]};
      mst.start();
      `CHK("st irq", m[i][3], irq)
      `CHK("start", 1'b1, st.start_seen)
      mst.stop();
      sw(4'h2);
    end
  endtask
  // counts, verdict, end of run
  task automatic stop_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, far beyond the expected run
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    {ctrl, dir, sadr, txd} = 32'h2618a45a;
    {txw, brd, iclr, oclr} = 4'h0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset();
    t_write();
    t_refuse();
    t_read();
    t_ten();
    t_modes();
    stop_test();
  end
endmodule
